/* File: bscs_map.vh */
`ifndef BSCS_MAP_VH
`define BSCS_MAP_VH
// ****************************************
// Register byte addresses on APB
// ****************************************
`define BSCS_ADDR_CTRL      12'h000
`define BSCS_ADDR_STATUS    12'h004
`define BSCS_ADDR_SEC       12'h008
`define BSCS_ADDR_SEC_PROG  12'h00C
`define BSCS_ADDR_ERASE     12'h010
`define BSCS_ADDR_PROG_CTRL 12'h014
// Security word index in loader space
`define BSCS_SEC_WORD_IDX   16'hFFFF
// ****************************************
// Security word field positions
// ****************************************
`define BSCS_SEC_LOCK       0
`define BSCS_SEC_TBL_INH    1
`define BSCS_SEC_ENCRYPT    2
`define BSCS_SEC_GAIN       7
`define BSCS_SEC_MSB        7
`define BSCS_SEC_ERASED     8'hFF
// ****************************************
// Control and status fields
// ****************************************
`define BSCS_CTRL_PROG_MODE 0
`define BSCS_PCR_LOADER_BIT 7
`define BSCS_STAT_LOADER    0
`define BSCS_STAT_SAMPLED   1
`define BSCS_STAT_BLOCKED   2
`define BSCS_ERASE_KEY      32'h0000A5E1
`define BSCS_ENC_KEY_RST    8'h5A
`endif

/* File: bscs_strap_sync.v */
// ****************************************
// Two-stage synchroniser for strap pins
// ****************************************
module bscs_strap_sync #(
  parameter WIDTH = 3
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // Straps idle high, so reset to ones
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_r;
endmodule // bscs_strap_sync

/* File: bscs_boot_security.v */
// Overview of operation
// R1 - Without forcing straps the device boots from the main application bank.
// R2 - Both port-2 straps low, or port-4 strap low, forces loader boot.
// R3 - Board holds strap and strobe pins at safe levels during reset.
// R4 - Security word sits at loader-space top; blocked in programming mode.
// R5 - A security bit programmed to zero returns to one only by erase-all; here any reset also reloads all ones.
// R6 - Lock bit zero refuses flash and security-setting access.
// R7 - Inhibit zero: table read from external code reaches external memory only.
// R8 - Table read from internal code may reach internal and external memory.
// R9 - Inhibit one: table reads are unrestricted.
// R10 - Encryption bit encodes port-0 data; only chip erase clears it. Here any reset also clears it.
// R11 - Gain bit zero halves oscillator gain; one keeps full gain.
// R12 - In forced loader boot, bit seven of programming control reads one.
// R13 - Straps sampled once at reset; boot bank held until next reset.
//
// Added by the designer: the APB register port.
`include "bscs_map.vh"
module bscs_boot_security #(
  parameter SAMPLE_CYCLES = 4
) (
  input  wire        core_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Board straps
  input  wire        port4_boot_strap,
  input  wire        port2_upper_strap_a,
  input  wire        port2_upper_strap_b,
  // Table-read path from the core
  input  wire        tbl_rd_req,
  input  wire        tbl_rd_from_ext,
  input  wire        tbl_rd_want_int,
  output reg         tbl_rd_int_en,
  // Multiplexed address/data port
  input  wire [7:0]  ad_port_data_in,
  output reg  [7:0]  ad_port_data_out,
  // Boot and oscillator outputs
  output reg         boot_from_loader,
  output reg         osc_gain_half,
  output reg         flash_access_en
);
  // ****************************************
  // Internal state and next values
  // ****************************************
  wire [2:0]  strap_sync;
  wire        force_loader;
  wire        apb_access;
  wire        apb_setup;
  wire        apb_wr_done;
  wire        sec_blocked;
  wire        erase_hit;
  wire [7:0]  enc_data;
  reg  [3:0]  samp_cnt_r;
  reg  [3:0]  samp_cnt_nxt;
  reg         samp_done_r;
  reg         samp_done_nxt;
  reg         loader_mode_r;
  reg         loader_mode_nxt;
  reg  [7:0]  sec_word_r;
  reg  [7:0]  sec_word_nxt;
  reg         prog_mode_r;
  reg         prog_mode_nxt;
  reg  [7:0]  enc_key_r;
  reg         tbl_int_nxt;
  reg  [7:0]  ad_out_nxt;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;

  // ****************************************
  // Strap synchronisation
  // ****************************************
  // Straps are asynchronous board inputs: two flops first
  bscs_strap_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({port4_boot_strap, port2_upper_strap_a, port2_upper_strap_b}),
    .pin_sync (strap_sync)
  );

  // Either strap pattern forces the loader bank
  assign force_loader = ~strap_sync[2] | (~strap_sync[1] & ~strap_sync[0]); // R2

  // ****************************************
  // One-time boot selection after reset
  // ****************************************
  // Wait for synchroniser to fill, then latch once
  always @* begin
    samp_cnt_nxt    = samp_cnt_r;
    samp_done_nxt   = samp_done_r;
    loader_mode_nxt = loader_mode_r;
    if (!samp_done_r) begin
      if (samp_cnt_r == SAMPLE_CYCLES[3:0]) begin
        samp_done_nxt   = 1'b1;
        loader_mode_nxt = force_loader; // R2 R13
      end else begin
        samp_cnt_nxt = samp_cnt_r + 4'h1;
      end
    end
  end

  // Boot state; only a reset reopens the sample window
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_r    <= 4'h0;
      samp_done_r   <= 1'b0;
      loader_mode_r <= 1'b0; // R1
    end else begin
      samp_cnt_r    <= samp_cnt_nxt;
      samp_done_r   <= samp_done_nxt;
      loader_mode_r <= loader_mode_nxt; // R13
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  assign apb_setup   = psel & ~penable;
  assign apb_access  = psel & penable & pready;
  assign apb_wr_done = apb_access & pwrite;
  assign sec_blocked = prog_mode_r | ~sec_word_r[`BSCS_SEC_LOCK]; // R4 R6
  assign erase_hit   = apb_wr_done & (paddr == `BSCS_ADDR_ERASE) & (pwdata == `BSCS_ERASE_KEY);

  // Read mux and error decode
  always @* begin
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    case (paddr)
      `BSCS_ADDR_CTRL: begin
        rdata_nxt[`BSCS_CTRL_PROG_MODE] = prog_mode_r;
      end
      `BSCS_ADDR_STATUS: begin
        rdata_nxt[`BSCS_STAT_LOADER]  = loader_mode_r;
        rdata_nxt[`BSCS_STAT_SAMPLED] = samp_done_r;
        rdata_nxt[`BSCS_STAT_BLOCKED] = sec_blocked;
      end
      `BSCS_ADDR_SEC, `BSCS_ADDR_SEC_PROG: begin
        if (sec_blocked) begin
          err_nxt = 1'b1; // R4 R6
        end else begin
          rdata_nxt[`BSCS_SEC_MSB:0] = sec_word_r;
        end
      end
      `BSCS_ADDR_ERASE: begin
        rdata_nxt = 32'h00000000;
      end
      `BSCS_ADDR_PROG_CTRL: begin
        rdata_nxt[`BSCS_PCR_LOADER_BIT] = loader_mode_r; // R12
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // Handshake flags: no wait states, answer in the first access cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & err_nxt; // R4 R6
    end
  end

  // Read data stands only in the access cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (apb_setup & ~pwrite) begin
      prdata <= rdata_nxt;
    end else if (apb_access) begin
      prdata <= 32'h00000000;
    end
  end

  // ****************************************
  // Security word and programming mode
  // ****************************************
  // Programming only clears bits; erase-all restores ones
  always @* begin
    sec_word_nxt  = sec_word_r;
    prog_mode_nxt = prog_mode_r;
    if (erase_hit) begin
      sec_word_nxt = `BSCS_SEC_ERASED; // R5 R10
    end else if (apb_wr_done) begin
      case (paddr)
        `BSCS_ADDR_CTRL: begin
          prog_mode_nxt = pwdata[`BSCS_CTRL_PROG_MODE];
        end
        `BSCS_ADDR_SEC_PROG: begin
          if (!sec_blocked) begin
            sec_word_nxt = sec_word_r & pwdata[`BSCS_SEC_MSB:0]; // R5 R4 R6
          end
        end
        default: begin
          sec_word_nxt = sec_word_r;
        end
      endcase
    end
  end

  // Security word, reset to the erased pattern
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_word_r <= `BSCS_SEC_ERASED;
    end else begin
      sec_word_r <= sec_word_nxt; // R5
    end
  end

  // Programming mode flag
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_mode_r <= 1'b0;
    end else begin
      prog_mode_r <= prog_mode_nxt;
    end
  end

  // ****************************************
  // Protection outputs
  // ****************************************
  // Key register for the port encoder
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_key_r <= `BSCS_ENC_KEY_RST;
    end else begin
      enc_key_r <= enc_key_r;
    end
  end

  // Table-read gating of internal flash
  always @* begin
    if (!tbl_rd_req) begin
      tbl_int_nxt = 1'b0;
    end else if (!tbl_rd_from_ext) begin
      tbl_int_nxt = tbl_rd_want_int; // R8
    end else if (sec_word_r[`BSCS_SEC_TBL_INH]) begin
      tbl_int_nxt = tbl_rd_want_int; // R9
    end else begin
      tbl_int_nxt = 1'b0; // R7
    end
  end

  // Nibble swap then key mix
  assign enc_data = {ad_port_data_in[3:0], ad_port_data_in[7:4]} ^ enc_key_r; // R10

  // Encoder bypassed while the active-low enable bit is high
  always @* begin
    if (!sec_word_r[`BSCS_SEC_ENCRYPT]) begin
      ad_out_nxt = enc_data; // R10
    end else begin
      ad_out_nxt = ad_port_data_in;
    end
  end

  // Table-read grant, one cycle after the request
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_rd_int_en <= 1'b0;
    end else begin
      tbl_rd_int_en <= tbl_int_nxt; // R7 R8 R9
    end
  end

  // Port data, encoded or passed through
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_port_data_out <= 8'h00;
    end else begin
      ad_port_data_out <= ad_out_nxt; // R10
    end
  end

  // Boot bank seen by the fetch unit
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_from_loader <= 1'b0;
    end else begin
      boot_from_loader <= loader_mode_r; // R1 R2 R13
    end
  end

  // Oscillator gain follows the gain bit
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_gain_half <= 1'b0;
    end else begin
      osc_gain_half <= ~sec_word_r[`BSCS_SEC_GAIN]; // R11
    end
  end

  // Flash access only after sampling and while unblocked
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_access_en <= 1'b0;
    end else begin
      flash_access_en <= samp_done_r & ~sec_blocked; // R6 R4
    end
  end
endmodule // bscs_boot_security

/* File: bscs_boot_security_checker.sv */
`include "bscs_map.vh"
module bscs_boot_security_checker #(
  parameter SAMPLE_CYCLES = 4
) (
  input wire        core_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        port4_boot_strap,
  input wire        port2_upper_strap_a,
  input wire        port2_upper_strap_b,
  input wire        tbl_rd_req,
  input wire        tbl_rd_from_ext,
  input wire        tbl_rd_want_int,
  input wire        tbl_rd_int_en,
  input wire [7:0]  ad_port_data_in,
  input wire [7:0]  ad_port_data_out,
  input wire        boot_from_loader,
  input wire        osc_gain_half,
  input wire        flash_access_en
);
  // Helper terms and setup sequences
  wire       int_req = tbl_rd_req && tbl_rd_want_int;
  wire [7:0] enc     = {ad_port_data_in[3:0], ad_port_data_in[7:4]} ^ 8'h5A;
  wire       ers_wr  = psel && penable && pwrite && pready && paddr == `BSCS_ADDR_ERASE;
  // Cycles since reset release; access flag valid once boot sampling is registered
  logic [4:0] rel_cnt_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_cnt_r <= 5'h00;
    end else if (rel_cnt_r <= SAMPLE_CYCLES + 2) begin
      rel_cnt_r <= rel_cnt_r + 5'h01;
    end
  end
  wire       settled = rel_cnt_r > SAMPLE_CYCLES + 2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_sec_blk;
    (paddr == `BSCS_ADDR_SEC || paddr == `BSCS_ADDR_SEC_PROG) && !flash_access_en && settled;
  endsequence
  // Boot, security and path checks
  a_loader_cause: assert property ($rose(boot_from_loader) |->
    !port4_boot_strap || !(port2_upper_strap_a || port2_upper_strap_b)) else $error("loader boot unforced");
  a_sec_refused: assert property (s_setup ##0 s_sec_blk |=> pready && pslverr)
    else $error("security access not refused");
  a_gain_erase: assert property ($fell(osc_gain_half) |-> $past(ers_wr) || $past(ers_wr, 2))
    else $error("gain bit returned without erase");
  a_tbl_cause: assert property (tbl_rd_int_en |-> $past(int_req)) else $error("internal read unasked");
  a_tbl_internal: assert property (int_req && !tbl_rd_from_ext |=> tbl_rd_int_en)
    else $error("internal code read blocked");
  a_port_code: assert property (ad_port_data_out == $past(ad_port_data_in) ||
    ad_port_data_out == $past(enc)) else $error("port data wrong");
  a_pcr_mode: assert property (s_setup ##0 (!pwrite && paddr == `BSCS_ADDR_PROG_CTRL) |=>
    pready && prdata[7] == boot_from_loader) else $error("mode bit wrong");
  a_boot_hold: assert property (boot_from_loader |=> boot_from_loader) else $error("boot bank lost");
endmodule // bscs_boot_security_checker
bind bscs_boot_security bscs_boot_security_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
  bscs_boot_security_checker_inst (.core_clk, .rst_n,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .port4_boot_strap, .port2_upper_strap_a,
  .port2_upper_strap_b, .tbl_rd_req, .tbl_rd_from_ext, .tbl_rd_want_int, .tbl_rd_int_en,
  .ad_port_data_in, .ad_port_data_out, .boot_from_loader, .osc_gain_half, .flash_access_en);

/* File: bscs_strap_model.sv */
module bscs_strap_model (
  input  wire [2:0] strap_cfg,
  output wire       port4_boot_strap,
  output wire       port2_upper_strap_a,
  output wire       port2_upper_strap_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Switches held steady through reset
  assign {port4_boot_strap, port2_upper_strap_a, port2_upper_strap_b} = strap_cfg;
endmodule // bscs_strap_model

/* File: test_bscs_boot_security.sv */
`include "bscs_map.vh"
module test_bscs_boot_security;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, s4, sa, sb, tie, bfl, ogh, fae;
  logic        trq = 0;
  logic        tex = 0;
  logic        twi = 0;
  logic [2:0]  cfg = 3'h7;
  logic [7:0]  adi = 8'h00;
  logic [7:0]  ado;
  logic [2:0]  cfgs [4] = '{3'h7, 3'h4, 3'h3, 3'h5};
  logic        exp_l [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
  int          err_total = 0;
  int          compares = 0;
  bscs_strap_model bscs_strap_model_inst (.strap_cfg(cfg), .port4_boot_strap(s4),
    .port2_upper_strap_a(sa), .port2_upper_strap_b(sb));
  bscs_boot_security #(.SAMPLE_CYCLES(4)) bscs_boot_security_inst (.core_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port4_boot_strap(s4), .port2_upper_strap_a(sa),
    .port2_upper_strap_b(sb), .tbl_rd_req(trq), .tbl_rd_from_ext(tex), .tbl_rd_want_int(twi),
    .tbl_rd_int_en(tie), .ad_port_data_in(adi), .ad_port_data_out(ado), .boot_from_loader(bfl),
    .osc_gain_half(ogh), .flash_access_en(fae));
  // Clock
  always #5 core_clk = ~core_clk;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task boot(input logic [2:0] c);
    cfg <= c;
    rst_n <= 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1;
    repeat (10) @(posedge core_clk);
  endtask
  task tr(input logic f, input logic e);
    @(posedge core_clk);
    {trq, tex, twi} <= {1'h1, f, 1'h1};
    @(posedge core_clk);
    #1 chk("tbl_rd_int_en", tie, e);
  endtask
  // Watchdog
  initial begin
    #20us;
    err_total++;
    end_sim;
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(cfgs[i]);
      apb(0, `BSCS_ADDR_PROG_CTRL, 0);
      chk("pcr_bit7", rd[7], exp_l[i]);
      chk("boot_from_loader", bfl, exp_l[i]);
      cfg <= ~cfgs[i];
      repeat (8) @(posedge core_clk);
      chk("boot_hold", bfl, exp_l[i]);
    end
    apb(0, `BSCS_ADDR_SEC, 0);
    chk("sec", rd, 32'hFF);
    chk("sec_ok_err", err, 0);
    tr(1, 1);
    apb(1, `BSCS_ADDR_SEC_PROG, 32'hFD);
    tr(1, 0);
    tr(0, 1);
    apb(1, `BSCS_ADDR_SEC_PROG, 32'hFF);
    apb(0, `BSCS_ADDR_SEC, 0);
    chk("sec", rd, 32'hFD);
    @(posedge core_clk);
    {adi, trq} <= {8'h3C, 1'h0};
    repeat (2) @(posedge core_clk);
    #1 chk("ad_out", ado, 8'h3C);
    apb(1, `BSCS_ADDR_SEC_PROG, 32'h7B);
    repeat (3) @(posedge core_clk);
    #1 chk("ad_out", ado, 8'h99);
    chk("osc_gain_half", ogh, 1);
    apb(1, `BSCS_ADDR_CTRL, 1);
    apb(0, `BSCS_ADDR_SEC, 0);
    chk("prog_err", err, 1);
    apb(1, `BSCS_ADDR_CTRL, 0);
    apb(1, `BSCS_ADDR_SEC_PROG, 32'hFE);
    apb(0, `BSCS_ADDR_SEC, 0);
    chk("lock_err", err, 1);
    chk("flash_access_en", fae, 0);
    apb(1, `BSCS_ADDR_ERASE, `BSCS_ERASE_KEY);
    apb(0, `BSCS_ADDR_SEC, 0);
    chk("sec_erased", rd, 32'hFF);
    apb(0, 12'h020, 0);
    chk("unmapped_err", err, 1);
    chk("osc_gain_half", ogh, 0);
    end_sim;
  end
endmodule // test_bscs_boot_security
